//--- verilog/lan_cfg_bank.sv
// configuration and ram pointer registers behind an axi4-lite slave
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lan_cfg_defs.svh"

// Overview of operation
// - wide_bus_enable 1 selects 16-bit host bus, 0 is 8-bit; reset 0.
// - chain_enable 1 turns on command chaining, 0 legacy; reset 0.
// - io mode: decode 0 gives 8K rom window, 1 gives 16K; reset 0.
// - memory mode: decode with rom enable picks 128K or 2K select region.
// - timeout select bits pick response and idle times from four pairs.
// - reconfiguration time 1680 ms for codes 00-10, 840 ms for 11.
// - reset sets both timeout select bits, shortest timeouts.
// - wait bit 1 drops ready for three clocks; reset 1.
// - wait bit 0 gives zero-wait arbitration and asserts zero-wait signal.
// - bit 1 selects io-mapped sequential or memory-mapped ram; reset 0.
// - transmitter disable bit stops transmitter, receiver keeps running.
// - pointer low bits 7-0 form ram address bits 7-0.
// - pointer high bits 2-0 are address 10-8; bit 6 is auto increment, others unused.
// - io mode: auto increment bit advances pointer after each data access.
// - config register read/write, loads 0x1c on hardware reset only.
// - memory select register reads five switch inputs and a one-hot decode of switches 2-0.
// - io mode data registers access ram at the pointer location.
// - with wide bus the ram appears as 1K words of 16 bits.
module lan_cfg_bank
#(
   parameter int ADDR_W = 11
)
(
   input  wire logic        mclk,               // 50 MHz clock
   input  wire logic        srst,               // hardware reset
   input  wire logic [7:0]  s_axi_awaddr,       // write address
   input  wire logic        s_axi_awvalid,      // write address valid
   output      logic        s_axi_awready,      // write address ready
   input  wire logic [31:0] s_axi_wdata,        // write data
   input  wire logic [3:0]  s_axi_wstrb,        // write strobes
   input  wire logic        s_axi_wvalid,       // write data valid
   output      logic        s_axi_wready,       // write data ready
   output      logic [1:0]  s_axi_bresp,        // write response
   output      logic        s_axi_bvalid,       // write response valid
   input  wire logic        s_axi_bready,       // write response ready
   input  wire logic [7:0]  s_axi_araddr,       // read address
   input  wire logic        s_axi_arvalid,      // read address valid
   output      logic        s_axi_arready,      // read address ready
   output      logic [31:0] s_axi_rdata,        // read data
   output      logic [1:0]  s_axi_rresp,        // read response
   output      logic        s_axi_rvalid,       // read data valid
   input  wire logic        s_axi_rready,       // read data ready
   input  wire logic [4:0]  mem_select_sw,      // memory select switches
   input  wire logic        rom_enable_input_n, // rom enable, active low
   input  wire logic        buffer_access,      // host buffer cycle strobe
   output      logic        iochrdy,            // host ready, low = wait
   output      logic        zero_wait_n,        // zero wait state, low
   output      logic        wide_bus,           // 16-bit bus selected
   output      logic        chain_on,           // command chaining on
   output      logic        io_mapped,          // io-mapped ram access
   output      logic        rom_16k,            // io mode rom window 16K
   output      logic        memcs16_2k,         // memcs16 decodes 2K block
   output      logic        tx_disable,         // transmitter stopped
   output      logic [15:0] response_time,      // 0.1 us units
   output      logic [15:0] idle_time,          // 0.1 us units
   output      logic [15:0] recon_time_ms,      // reconfiguration, ms
   output      logic [10:0] ram_address         // current pointer
);
   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   lan_cfg_pkg::reg8_t     mode_config;
   lan_cfg_pkg::reg8_t     ram_pointer_low;
   lan_cfg_pkg::reg8_t     ram_pointer_high;
   lan_cfg_pkg::bus_state_t state;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        aw_held;
   logic        w_held;
   logic [1:0]  wait_cnt;
   logic        access_q;
   logic        wait_start;
   logic [7:0]  mem_select;
   logic [7:0]  ram_rd_lo;
   logic [7:0]  ram_rd_hi;
   logic        do_write;
   logic        do_read;
   logic        data_wr;
   logic        data_rd;
   logic        ram_we_lo;
   logic        ram_we_hi;
   logic [10:0] next_ptr;
   logic [10:0] step;

   function automatic logic is_data(input logic [7:0] a);
      is_data = (a == `OFS_DATA_LOW) || (a == `OFS_DATA_HIGH);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         `OFS_MODE_CONFIG, `OFS_PTR_LOW, `OFS_PTR_HIGH, `OFS_DATA_LOW,
         `OFS_DATA_HIGH, `OFS_MEM_SELECT, `OFS_TIMEOUTS:
            is_mapped = 1'b1;
         default:
            is_mapped = 1'b0;
      endcase
   endfunction

   //------------------------------------------------------------
   // axi4-lite handshake
   //------------------------------------------------------------
   assign s_axi_awready = (state == lan_cfg_pkg::bus_idle) && !aw_held;
   assign s_axi_wready  = (state == lan_cfg_pkg::bus_idle) && !w_held;
   assign s_axi_arready = (state == lan_cfg_pkg::bus_idle)
                          && !aw_held && !w_held;
   assign do_write = (state == lan_cfg_pkg::bus_idle) && aw_held && w_held;
   assign do_read  = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         state <= lan_cfg_pkg::bus_idle;
      else
         case (state)
            lan_cfg_pkg::bus_idle:
               if (do_write)
                  state <= lan_cfg_pkg::bus_wresp;
               else if (do_read)
                  state <= lan_cfg_pkg::bus_rresp;
            lan_cfg_pkg::bus_wresp:
               if (s_axi_bready)
                  state <= lan_cfg_pkg::bus_idle;
            lan_cfg_pkg::bus_rresp:
               if (s_axi_rready)
                  state <= lan_cfg_pkg::bus_idle;
            default:
               state <= lan_cfg_pkg::bus_idle;
         endcase
   end

   assign s_axi_bvalid = (state == lan_cfg_pkg::bus_wresp);
   assign s_axi_rvalid = (state == lan_cfg_pkg::bus_rresp);

   always_ff @(posedge mclk)
   begin
      if (srst)
         s_axi_bresp <= 2'h0;
      else if (do_write)
         s_axi_bresp <= is_mapped(aw_addr) ? 2'h0 : 2'h2;
   end

   //------------------------------------------------------------
   // configuration register
   //------------------------------------------------------------
   // srst only; a software reset leaves it alone
   always_ff @(posedge mclk)
   begin
      if (srst)
         mode_config <= `MODE_CONFIG_RESET;
      else if (do_write && aw_addr == `OFS_MODE_CONFIG && w_strb[0])
         mode_config <= w_data[7:0];
   end

   assign wide_bus   = mode_config[`BIT_WIDE_BUS];
   assign chain_on   = mode_config[`BIT_CHAIN];
   assign io_mapped  = mode_config[`BIT_IO_ACCESS];
   assign tx_disable = mode_config[`BIT_TX_DISABLE];
   assign rom_16k    = io_mapped && mode_config[`BIT_DECODE];
   // memcs16 follows the 2K decode only while the rom decode is enabled
   assign memcs16_2k = !io_mapped && mode_config[`BIT_DECODE]
                       && !rom_enable_input_n;

   always_comb
   begin
      case ({mode_config[`BIT_TSEL_UPPER], mode_config[`BIT_TSEL_LOWER]})
         2'b00:
         begin
            response_time = `RESP_T00;
            idle_time     = `IDLE_T00;
         end
         2'b01:
         begin
            response_time = `RESP_T01;
            idle_time     = `IDLE_T01;
         end
         2'b10:
         begin
            response_time = `RESP_T10;
            idle_time     = `IDLE_T10;
         end
         default:
         begin
            response_time = `RESP_T11;
            idle_time     = `IDLE_T11;
         end
      endcase
   end

   assign recon_time_ms = (mode_config[`BIT_TSEL_UPPER]
                           && mode_config[`BIT_TSEL_LOWER])
                          ? `RECON_SHORT_MS : `RECON_LONG_MS;

   //------------------------------------------------------------
   // wait state generation
   //------------------------------------------------------------
   // one wait state per host cycle, however long the cycle lasts
   assign wait_start = buffer_access && !access_q && mode_config[`BIT_WAIT];

   always_ff @(posedge mclk)
      access_q <= srst ? 1'b0 : buffer_access;

   always_ff @(posedge mclk)
   begin
      if (srst)
         wait_cnt <= 2'h0;
      else if (wait_start)
         wait_cnt <= `WAIT_CYCLES;
      else if (wait_cnt != 2'h0)
         wait_cnt <= wait_cnt - 2'h1;
   end

   assign iochrdy     = (wait_cnt == 2'h0) && !wait_start;
   assign zero_wait_n = !(buffer_access && !mode_config[`BIT_WAIT]);

   //------------------------------------------------------------
   // address pointer and data access
   //------------------------------------------------------------
   assign ram_address = {ram_pointer_high[2:0], ram_pointer_low};
   assign data_wr = do_write && is_data(aw_addr) && io_mapped;
   assign data_rd = do_read && is_data(s_axi_araddr) && io_mapped;
   // word mode takes both lanes at once and steps by two bytes
   assign step     = wide_bus ? 11'h002 : 11'h001;
   assign next_ptr = ram_address + step;
   assign ram_we_lo = data_wr && w_strb[0]
                      && (wide_bus || aw_addr == `OFS_DATA_LOW);
   assign ram_we_hi = data_wr && wide_bus && w_strb[1];

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ram_pointer_low  <= 8'h00;
         ram_pointer_high <= 8'h00;
      end
      else if (do_write && aw_addr == `OFS_PTR_LOW && w_strb[0])
         ram_pointer_low <= w_data[7:0];
      else if (do_write && aw_addr == `OFS_PTR_HIGH && w_strb[0])
         ram_pointer_high <= w_data[7:0] & `PTR_HIGH_MASK;
      else if ((data_wr || data_rd) && ram_pointer_high[`BIT_AUTO_INC])
      begin
         ram_pointer_low       <= next_ptr[7:0];
         ram_pointer_high[2:0] <= next_ptr[10:8];
      end
   end

   lan_buffer_ram
   #(
      .ADDR_W (ADDR_W)
   )
   u_ram
   (
      .mclk     (mclk),
      .we_lo    (ram_we_lo),
      .we_hi    (ram_we_hi),
      .addr     (ram_address),
      .wdata_lo (w_data[7:0]),
      .wdata_hi (w_data[15:8]),
      .rdata_lo (ram_rd_lo),
      .rdata_hi (ram_rd_hi)
   );

   //------------------------------------------------------------
   // read path
   //------------------------------------------------------------
   // one-hot view of switch bits 2-0
   always_comb
   begin
      mem_select = 8'h00;
      mem_select[mem_select_sw[2:0]] = 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end
      else if (do_read)
      begin
         s_axi_rresp <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
         case (s_axi_araddr)
            `OFS_MODE_CONFIG:
               s_axi_rdata <= {24'h000000, mode_config};
            `OFS_PTR_LOW:
               s_axi_rdata <= {24'h000000, ram_pointer_low};
            `OFS_PTR_HIGH:
               s_axi_rdata <= {24'h000000, ram_pointer_high};
            `OFS_DATA_LOW:
               s_axi_rdata <= wide_bus ? {16'h0000, ram_rd_hi, ram_rd_lo}
                              : {24'h000000, ram_rd_lo};
            `OFS_DATA_HIGH:
               s_axi_rdata <= {24'h000000, ram_rd_hi};
            `OFS_MEM_SELECT:
               s_axi_rdata <= {19'h00000, mem_select_sw, mem_select};
            `OFS_TIMEOUTS:
               s_axi_rdata <= {recon_time_ms, response_time};
            default:
               s_axi_rdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

//--- inc/lan_cfg_defs.svh
// offsets, field positions, reset values and timing figures of the config bank
`ifndef LAN_CFG_DEFS_SVH
`define LAN_CFG_DEFS_SVH

`define OFS_MODE_CONFIG      8'h00
`define OFS_PTR_LOW          8'h04
`define OFS_PTR_HIGH         8'h08
`define OFS_DATA_LOW         8'h0c
`define OFS_DATA_HIGH        8'h10
`define OFS_MEM_SELECT       8'h14
`define OFS_TIMEOUTS         8'h18

`define BIT_WIDE_BUS         7
`define BIT_CHAIN            6
`define BIT_DECODE           5
`define BIT_TSEL_UPPER       4
`define BIT_TSEL_LOWER       3
`define BIT_WAIT             2
`define BIT_IO_ACCESS        1
`define BIT_TX_DISABLE       0
`define BIT_AUTO_INC         6

`define MODE_CONFIG_RESET    8'h1c
`define PTR_HIGH_MASK        8'h47

// response / idle times in tenths of microseconds, reconfig time in ms
`define RESP_T00             16'h2ea0
`define RESP_T01             16'h1750
`define RESP_T10             16'h0ba8
`define RESP_T11             16'h02eb
`define IDLE_T00             16'h3340
`define IDLE_T01             16'h19a0
`define IDLE_T10             16'h0cd0
`define IDLE_T11             16'h0334
`define RECON_LONG_MS        16'h0690
`define RECON_SHORT_MS       16'h0348

`define WAIT_CYCLES          2'h2

`endif

//--- inc/lan_cfg_pkg.sv
// types shared by the configuration bank files
package lan_cfg_pkg;
   typedef enum logic [1:0]
   {
      bus_idle  = 2'b00,
      bus_wresp = 2'b01,
      bus_rresp = 2'b11
   } bus_state_t;

   typedef logic [7:0] reg8_t;
endpackage

//--- verilog/lan_buffer_ram.sv
// on-chip 2k x 8 buffer ram with byte and word port
`timescale 1ns/1ps
module lan_buffer_ram
#(
   parameter int ADDR_W = 11
)
(
   input  wire logic              mclk,      // system clock
   input  wire logic              we_lo,     // write low byte
   input  wire logic              we_hi,     // write high byte (word mode)
   input  wire logic [ADDR_W-1:0] addr,      // byte address
   input  wire logic [7:0]        wdata_lo,  // low byte in
   input  wire logic [7:0]        wdata_hi,  // high byte in
   output      logic [7:0]        rdata_lo,  // byte at addr
   output      logic [7:0]        rdata_hi   // byte at addr | 1
);
   logic [7:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] addr_hi;

   // word lanes pair the even byte with the odd one above it
   assign addr_hi = addr | {{(ADDR_W-1){1'b0}}, 1'b1};

   always_ff @(posedge mclk)
   begin
      if (we_lo)
         mem[addr] <= wdata_lo;
      if (we_hi)
         mem[addr_hi] <= wdata_hi;
   end

   assign rdata_lo = mem[addr];
   assign rdata_hi = mem[addr_hi];
endmodule

//--- verification/lan_cfg_bank_sva.sv
// assertions on the configuration bank ports
`timescale 1ns/1ps
module lan_cfg_bank_sva
(
   input wire logic        mclk,               // clock
   input wire logic        srst,               // reset
   input wire logic        s_axi_awready,      // aw ready
   input wire logic        s_axi_wready,       // w ready
   input wire logic [1:0]  s_axi_bresp,        // b resp
   input wire logic        s_axi_bvalid,       // b valid
   input wire logic        s_axi_bready,       // b ready
   input wire logic        s_axi_arvalid,      // ar valid
   input wire logic        s_axi_arready,      // ar ready
   input wire logic        s_axi_rvalid,       // r valid
   input wire logic        rom_enable_input_n, // rom enable
   input wire logic        buffer_access,      // buffer cycle
   input wire logic        iochrdy,            // host ready
   input wire logic        zero_wait_n,        // zero wait
   input wire logic        wide_bus,           // 16-bit
   input wire logic        chain_on,           // chaining
   input wire logic        io_mapped,          // io mode
   input wire logic        rom_16k,            // rom window
   input wire logic        memcs16_2k,         // select region
   input wire logic        tx_disable,         // tx off
   input wire logic [15:0] response_time,      // response
   input wire logic [15:0] idle_time,          // idle
   input wire logic [15:0] recon_time_ms,      // reconfig
   input wire logic [10:0] ram_address         // pointer
);
   logic tsel_ok;

   // -----
   // timeout table
   // -----
   assign tsel_ok = {response_time, idle_time, recon_time_ms} inside
      {48'h2ea0_3340_0690, 48'h1750_19a0_0690, 48'h0ba8_0cd0_0690,
       48'h02eb_0334_0348};

   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (srst);

   sequence wait_begin;
      !buffer_access ##1 buffer_access && !iochrdy;
   endsequence
   sequence wait_run;
      !iochrdy [*2] ##1 iochrdy;
   endsequence

   chk_reset_fields: assert property (
      $fell(srst) |-> !wide_bus && !chain_on && !io_mapped && !tx_disable
         && response_time == 16'h02eb && ram_address == 11'h000)
      else $error("fields wrong after reset");
   chk_timeout_set: assert property (tsel_ok)
      else $error("timeout outputs disagree");
   chk_rom_window: assert property (
      rom_16k |-> io_mapped && !memcs16_2k)
      else $error("rom window outside io mode");
   chk_mem_decode: assert property (
      memcs16_2k |-> !io_mapped && !rom_enable_input_n)
      else $error("memory select decode wrong");
   chk_wait_state: assert property (wait_begin |=> wait_run)
      else $error("wait state length wrong");
   chk_zero_wait: assert property (
      !zero_wait_n |-> buffer_access && iochrdy)
      else $error("zero wait outside buffer cycle");
   chk_resp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_busy_refuse: assert property (
      s_axi_bvalid || s_axi_rvalid |-> !s_axi_awready && !s_axi_wready
         && !s_axi_arready)
      else $error("request taken while response pending");
endmodule

//--- verification/lan_host_model.sv
// host-side register bus master model
`timescale 1ns/1ps
module lan_host_model
(
   input  wire logic        mclk,          // clock
   input  wire logic        slow,          // late response ready
   output      logic [7:0]  s_axi_awaddr,  // aw addr
   output      logic        s_axi_awvalid, // aw valid
   input  wire logic        s_axi_awready, // aw ready
   output      logic [31:0] s_axi_wdata,   // w data
   output      logic [3:0]  s_axi_wstrb,   // w strobes
   output      logic        s_axi_wvalid,  // w valid
   input  wire logic        s_axi_wready,  // w ready
   input  wire logic [1:0]  s_axi_bresp,   // b resp
   input  wire logic        s_axi_bvalid,  // b valid
   output      logic        s_axi_bready,  // b ready
   output      logic [7:0]  s_axi_araddr,  // ar addr
   output      logic        s_axi_arvalid, // ar valid
   input  wire logic        s_axi_arready, // ar ready
   input  wire logic [31:0] s_axi_rdata,   // r data
   input  wire logic [1:0]  s_axi_rresp,   // r resp
   input  wire logic        s_axi_rvalid,  // r valid
   output      logic        s_axi_rready   // r ready
);
   logic [1:0]  bresp_q = 2'b00;
   logic [1:0]  rresp_q = 2'b00;
   logic [31:0] rdata_q = 32'h0;
   int          bcnt = 0;
   int          rcnt = 0;

   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
      s_axi_rready = 1'b0;
   end

   // scramble released payload
   always @(posedge mclk)
   begin
      if (s_axi_awvalid && s_axi_awready)
      begin
         s_axi_awvalid <= 1'b0;
         s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         s_axi_wvalid <= 1'b0;
         s_axi_wdata <= ~s_axi_wdata;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arvalid <= 1'b0;
         s_axi_araddr <= ~s_axi_araddr;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_bready <= 1'b0;
         bresp_q <= s_axi_bresp;
         bcnt <= bcnt + 1;
      end
      else if (s_axi_bvalid)
         s_axi_bready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rready <= 1'b0;
         {rresp_q, rdata_q} <= {s_axi_rresp, s_axi_rdata};
         rcnt <= rcnt + 1;
      end
      else if (s_axi_rvalid)
         s_axi_rready <= 1'b1;
   end

   // called right after a rising edge
   task automatic write_word(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
      int n;
      n = bcnt;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
      while (bcnt == n)
         @(posedge mclk);
      r = bresp_q;
   endtask

   task automatic read_word(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
      int n;
      n = rcnt;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      while (rcnt == n)
         @(posedge mclk);
      {r, d} = {rresp_q, rdata_q};
   endtask
endmodule

//--- verification/lan_cfg_bank_bench.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`include "lan_cfg_defs.svh"
module lan_cfg_bank_bench;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        slow = 1'b0;
   logic        buffer_access = 1'b0;
   logic        rom_enable_input_n = 1'b1;
   logic [4:0]  mem_select_sw = 5'h00;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, cfg, lo, hi;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, iochrdy, zero_wait_n;
   logic        wide_bus, chain_on, io_mapped, rom_16k, memcs16_2k, tx_disable;
   logic [15:0] response_time, idle_time, recon_time_ms, w;
   logic [10:0] ram_address, base;
   logic [7:0]  b [3];
   int          failures = 0;
   int          check_count = 0;
   int          seed = 32'h9a69;

   always #10 mclk = ~mclk;

   lan_cfg_bank lan_cfg_bank_inst (.mclk, .srst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .mem_select_sw, .rom_enable_input_n, .buffer_access, .iochrdy,
      .zero_wait_n, .wide_bus, .chain_on, .io_mapped, .rom_16k, .memcs16_2k,
      .tx_disable, .response_time, .idle_time, .recon_time_ms, .ram_address);

   lan_host_model host_inst (.mclk, .slow, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   // -----
   // checking and bus helpers
   // -----
   task automatic check(input string what, input logic [47:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] er);
      logic [1:0] r;
      host_inst.write_word(a, v, r);
      check("bresp", r, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      logic [1:0] r;
      host_inst.read_word(a, d, r);
      check("rresp", r, er);
   endtask

   task automatic setp(input logic [10:0] a, input logic inc);
      wr(`OFS_PTR_LOW, {24'h0, a[7:0]}, 2'b00);
      wr(`OFS_PTR_HIGH, {24'h0, 1'b0, inc, 3'b000, a[10:8]}, 2'b00);
   endtask

   task automatic pulse(input logic exp_rdy, input logic exp_zw);
      @(posedge mclk);
      buffer_access <= 1'b1;
      @(posedge mclk);
      #1;
      check("iochrdy", iochrdy, exp_rdy);
      check("zero_wait_n", zero_wait_n, exp_zw);
      repeat (4) @(posedge mclk);
      buffer_access <= 1'b0;
   endtask

   function automatic logic [5:0] fields(input logic [7:0] c, input logic rn);
      fields = {c[7], c[6], c[1] & c[5], !c[1] & c[5] & !rn, c[1], c[0]};
   endfunction

   function automatic logic [47:0] times(input logic [1:0] c);
      case (c)
         2'b00: times = 48'h2ea0_3340_0690;
         2'b01: times = 48'h1750_19a0_0690;
         2'b10: times = 48'h0ba8_0cd0_0690;
         default: times = 48'h02eb_0334_0348;
      endcase
   endfunction

   // a hang counts as a mismatch
   initial
   begin
      repeat (5000) @(posedge mclk);
      failures++;
      report_and_stop();
   end

   initial
   begin
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rd(`OFS_MODE_CONFIG, 2'b00);
      check("mode_config", d[7:0], 8'h1c);
      pulse(1'b0, 1'b1);
      for (int i = 0; i < 16; i++)
      begin
         cfg = 8'($random(seed));
         cfg[4:3] = i[1:0];
         slow <= 1'($random(seed));
         rom_enable_input_n <= i[2];
         wr(`OFS_MODE_CONFIG, {24'h0, cfg}, 2'b00);
         rd(`OFS_MODE_CONFIG, 2'b00);
         check("mode_config", d[7:0], cfg);
         check("fields", {wide_bus, chain_on, rom_16k, memcs16_2k, io_mapped,
               tx_disable}, fields(cfg, i[2]));
         check("timeouts", {response_time, idle_time, recon_time_ms},
               times(cfg[4:3]));
      end
      wr(`OFS_MODE_CONFIG, 32'h02, 2'b00);
      pulse(1'b1, 1'b0);
      lo = 8'($random(seed));
      hi = 8'($random(seed)) | 8'h40;
      wr(`OFS_PTR_LOW, {24'h0, lo}, 2'b00);
      wr(`OFS_PTR_HIGH, {24'h0, hi}, 2'b00);
      base = {hi[2:0], lo};
      check("ram_address", ram_address, base);
      rd(`OFS_PTR_HIGH, 2'b00);
      check("ptr_high", d[7:0], hi & 8'h47);
      for (int k = 0; k < 3; k++)
      begin
         b[k] = 8'($random(seed));
         wr(`OFS_DATA_LOW, {24'h0, b[k]}, 2'b00);
         check("ram_address", ram_address, 11'(base + k + 1));
      end
      setp(base, 1'b1);
      for (int k = 0; k < 3; k++)
      begin
         rd(`OFS_DATA_LOW, 2'b00);
         check("ram byte", d[7:0], b[k]);
      end
      wr(`OFS_MODE_CONFIG, 32'h82, 2'b00);
      base[0] = 1'b0;
      setp(base, 1'b1);
      w = 16'($random(seed));
      wr(`OFS_DATA_LOW, {16'h0, w}, 2'b00);
      check("ram_address", ram_address, 11'(base + 2));
      setp(base, 1'b0);
      rd(`OFS_DATA_LOW, 2'b00);
      check("ram word", d[15:0], w);
      check("ram_address", ram_address, base);
      wr(`OFS_MODE_CONFIG, 32'h00, 2'b00);
      setp(base, 1'b1);
      wr(`OFS_DATA_LOW, 32'h3c, 2'b00);
      check("ram_address", ram_address, base);
      mem_select_sw <= 5'($random(seed));
      rd(`OFS_MEM_SELECT, 2'b00);
      check("mem_select", d[12:0],
            {mem_select_sw, 8'h01 << mem_select_sw[2:0]});
      rd(8'h1c, 2'b10);
      check("unmapped read", d, 32'h0);
      wr(8'h1c, 32'h5a, 2'b10);
      srst <= 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rd(`OFS_MODE_CONFIG, 2'b00);
      check("mode_config", d[7:0], 8'h1c);
      report_and_stop();
   end
endmodule

bind lan_cfg_bank lan_cfg_bank_sva lan_cfg_bank_sva_inst (.mclk, .srst,
   .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .rom_enable_input_n, .buffer_access, .iochrdy, .zero_wait_n, .wide_bus,
   .chain_on, .io_mapped, .rom_16k, .memcs16_2k, .tx_disable,
   .response_time, .idle_time, .recon_time_ms, .ram_address);
